// >>> rtl/fsc_defines.vh
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
// ==========================================================
// Register byte offsets
`define FSC_A_CNT_LO    8'h00
`define FSC_A_CNT_MID   8'h04
`define FSC_A_CMD       8'h0c
`define FSC_A_STAT      8'h10
`define FSC_A_ISTAT     8'h14
`define FSC_A_PERIOD    8'h18
`define FSC_A_OFFSET    8'h1c
`define FSC_A_CTRL1     8'h20
`define FSC_A_CCF       8'h24
`define FSC_A_CTRL3     8'h30
`define FSC_A_CNT_HI    8'h38
`define FSC_A_DCMD      8'h40
`define FSC_A_DSTC      8'h44
`define FSC_A_DSPA      8'h48
`define FSC_A_DSTAT     8'h54
// ==========================================================
// Field positions
`define FSC_DCMD_INTE_D 6
`define FSC_DCMD_INTE_P 5
`define FSC_DCMD_MDL    4
`define FSC_DS_ERR      0
`define FSC_DS_POWER_DOWN_PIN     1
`define FSC_DS_DONE     3
`define FSC_DS_SCSI     4
`define FSC_DS_PAGE     5
`define FSC_C1_PAR_EN   4
`define FSC_C1_RST_IEN  6
`define FSC_C3_FCLK     3
`define FSC_C3_FAST     4
`define FSC_ST_PERR     5
`define FSC_IS_RST      7
`define FSC_IS_ILL      6
`define FSC_IS_DISC     5
`define FSC_IS_SVC      4
`define FSC_IS_DONE     3
`define FSC_IS_RESEL    2
// ==========================================================
// Command codes and constants
`define FSC_CMD_NOP     8'h00
`define FSC_CMD_NOP_D   8'h80
`define FSC_CMD_DEVRST  8'h02
`define FSC_CMD_BUSRST  8'h03
`define FSC_CMD_SETATN  8'h1a
`define FSC_CMD_CLRATN  8'h1b
`define FSC_FIFO_THR    2
`define FSC_DCMD_RST    8'h00
`define FSC_DSTC_MASK   32'h00ffffff
`endif

// >>> rtl/fsc_core.v
`include "fsc_defines.vh"

// Functional notes
// (R1) Reading the DMA status clears each DMA interrupt flag it returned.
// (R2) SCSI interrupt stays until status, state and interrupt status are read.
// (R3) DMA done or PCI address error interrupts only with command bit 6 set.
// (R4) The first assertion of the power-down pin raises an interrupt.
// (R5) Descriptor-list page completion interrupts only with command bit 5 set.
// (R6) Any SCSI interrupt sets DMA status bit 4.
// (R7) SCSI interrupts: reset, illegal code, disconnect, service, done, reselect.
// (R8) Count high byte reads a fixed identity code until the counter loads.
// (R9) FIFO tells DMA it is ready once two bytes are reached.
// (R10) Software sets fast bits, conversion factor 000 and period 04h for speed.
// (R11) Period register low five bits set the synchronous transfer period.
// (R12) Offset bits 7:6 shift REQ/ACK deassertion, mapping depends on fast clock.
// (R13) Offset bits 5:4 delay REQ/ACK assertion from zero to two clocks.
// (R14) SCSI parity is odd over eight data lines and parity line.
// (R15) Parity is always generated for every byte driven onto the bus.
// (R16) Control one bit 4 enables incoming parity check; hard reset clears it.
// (R17) Parity error sets status bit 5 and asserts ATN, no interrupt.
// (R18) Reset-device command resets the SCSI side only, not DMA registers.
// (R19) After reset-device, software must issue a no-operation command first.
// (R20) SCSI RST is bidirectional; an external assertion soft resets logic.
// (R21) Reset-bus command soft resets and drives RST until hard reset.
// (R22) Software reloads counts and address per element and restarts engines.
// (R23) Command 02h performs hard reset, 03h performs SCSI bus reset.
// (R24) Soft reset releases bus signals, disconnects, interrupts if bit 6 set.
// (R25) As initiator, bus free or selection timeout deasserts signals and empties command.
// (R26) Interrupt output follows any enabled DMA flag or SCSI summary flag.
module fsc_core #(
  parameter       FIFO_LW  = 7,
  parameter [7:0] BLOCK_ID = 8'h5a  // Arbitrary neutral identity value
) (
  input  wire               clk,
  input  wire               sys_rst,
  input  wire [7:0]         reg_addr,
  input  wire               reg_wr,
  input  wire               reg_rd,
  input  wire [31:0]        reg_wdata,
  output reg  [31:0]        reg_rdata_r,
  output reg                int_n_r,
  input  wire               dma_done_evt,
  input  wire               dma_addr_err_evt,
  input  wire               dma_page_evt,
  input  wire               power_down_pin,
  input  wire [3:0]         seq_evt,
  input  wire               bus_free_evt,
  input  wire               sel_timeout_evt,
  input  wire               initiator,
  input  wire [2:0]         seq_state,
  input  wire               xfer_byte,
  input  wire [FIFO_LW-1:0] fifo_level,
  output reg                fifo_dma_ready_r,
  output reg  [7:0]         cmd_code_r,
  output reg                cmd_valid_r,
  output reg                count_zero_r,
  output reg                sync_tick_r,
  output reg                fast_timing_enable_r,
  output reg                fast_clock_enable_r,
  output reg  [2:0]         clk_conv_r,
  input  wire               hs_req,
  output reg                scsi_reqack_r,
  input  wire [7:0]         tx_data,
  input  wire               tx_valid,
  output reg  [7:0]         scsi_db_out_r,
  output reg                scsi_dbp_out_r,
  output reg                scsi_db_oe_r,
  input  wire [7:0]         scsi_db_in,
  input  wire               scsi_dbp_in,
  input  wire               rx_strobe,
  output reg                scsi_atn_r,
  input  wire               scsi_rst_in,
  output reg                scsi_rst_out_r,
  output reg                scsi_rst_oe_r,
  output reg                disconnected_r
);

  // ========================================================
  // Pin synchronisers
  reg [2:0] rst_sy_r;
  reg [2:0] pd_sy_r;
  reg       rst_lvl_r;
  reg       pd_lvl_r;
  reg       pd_seen_r;
  reg [7:0] db_s1_r;
  reg [7:0] db_s2_r;
  reg       dbp_s1_r;
  reg       dbp_s2_r;
  reg [1:0] rxs_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      rst_sy_r  <= 3'h0;
      pd_sy_r   <= 3'h0;
      rst_lvl_r <= 1'b0;
      pd_lvl_r  <= 1'b0;
      rxs_r     <= 2'h0;
    end else begin
      rst_sy_r <= {rst_sy_r[1:0], scsi_rst_in};
      pd_sy_r  <= {pd_sy_r[1:0], power_down_pin};
      if (rst_sy_r[1] == rst_sy_r[2])
        rst_lvl_r <= rst_sy_r[2];
      if (pd_sy_r[1] == pd_sy_r[2])
        pd_lvl_r <= pd_sy_r[2];
      rxs_r <= {rxs_r[0], rx_strobe};
    end
    db_s1_r  <= scsi_db_in;
    db_s2_r  <= db_s1_r;
    dbp_s1_r <= scsi_dbp_in;
    dbp_s2_r <= dbp_s1_r;
  end

  wire pd_first  = pd_sy_r[2] & (pd_sy_r[1] == pd_sy_r[2]) &
                   ~pd_lvl_r & ~pd_seen_r;                    // [R4]
  wire ext_rst   = rst_sy_r[2] & (rst_sy_r[1] == rst_sy_r[2]) &
                   ~rst_lvl_r & ~scsi_rst_oe_r;               // [R20]
  wire rx_check  = rxs_r[1];
  wire par_bad   = ~(^{db_s2_r, dbp_s2_r});                   // [R14]

  // ========================================================
  // Command decode
  wire       wr_cmd  = reg_wr & (reg_addr == `FSC_A_CMD);
  wire [7:0] wcode   = reg_wdata[7:0];
  reg        need_nop_r;
  reg        legal;
  always @* begin
    case (wcode)
      8'h00, 8'h80, 8'h01, 8'h02, 8'h03,
      8'h10, 8'h90, 8'h11, 8'h91, 8'h12, 8'h98, 8'h1a, 8'h1b,
      8'h41, 8'hc1, 8'h42, 8'hc2, 8'h43, 8'hc3,
      8'h44, 8'hc4, 8'h45, 8'h46, 8'hc6: legal = 1'b1;
      default:                           legal = 1'b0;
    endcase
  end
  wire is_nop   = (wcode == `FSC_CMD_NOP) | (wcode == `FSC_CMD_NOP_D);
  wire cmd_take = wr_cmd & legal & (~need_nop_r | is_nop);    // [R19]
  wire dev_rst  = cmd_take & (wcode == `FSC_CMD_DEVRST);      // [R23]
  wire bus_rst  = cmd_take & (wcode == `FSC_CMD_BUSRST);      // [R23]
  wire cmd_ill  = wr_cmd & ~legal;
  wire hrst     = sys_rst | dev_rst;                          // [R18]
  wire srst     = bus_rst | ext_rst;
  wire drst     = initiator & (bus_free_evt | sel_timeout_evt);

  // ========================================================
  // SCSI registers
  reg [23:0] start_cnt_r;
  reg [23:0] cur_cnt_r;
  reg        id_valid_r;
  reg [7:0]  period_r;
  reg [7:0]  offset_r;
  reg [7:0]  ctrl1_r;
  reg [7:0]  ctrl3_r;
  reg        perr_r;
  reg [7:0]  istat_r;
  reg [2:0]  seen_r;
  wire rd_stat  = reg_rd & (reg_addr == `FSC_A_STAT);
  wire rd_state = reg_rd & (reg_addr == `FSC_A_PERIOD);
  wire rd_istat = reg_rd & (reg_addr == `FSC_A_ISTAT);
  wire [7:0] ev;
  assign ev[`FSC_IS_RST]   = srst & ctrl1_r[`FSC_C1_RST_IEN]; // [R24]
  assign ev[`FSC_IS_ILL]   = cmd_ill;                         // [R7]
  assign ev[`FSC_IS_DISC]  = seq_evt[0];                      // [R7]
  assign ev[`FSC_IS_SVC]   = seq_evt[1];                      // [R7]
  assign ev[`FSC_IS_DONE]  = seq_evt[2];                      // [R7]
  assign ev[`FSC_IS_RESEL] = seq_evt[3];                      // [R7]
  assign ev[1:0]           = 2'h0;
  wire [2:0] seen_nxt = seen_r | {rd_istat, rd_state, rd_stat};
  wire scsi_clr = (&seen_nxt) & (|istat_r) & ~(|ev);          // [R2]
  wire perr_evt = rx_check & ctrl1_r[`FSC_C1_PAR_EN] & par_bad; // [R16]
  wire dma_cmd  = cmd_take & wcode[7];
  wire wr_hi    = reg_wr & (reg_addr == `FSC_A_CNT_HI);
  always @(posedge clk) begin
    if (hrst) begin
      start_cnt_r <= 24'h0;
      cur_cnt_r   <= 24'h0;
      id_valid_r  <= 1'b1;
      period_r    <= 8'h0;
      offset_r    <= 8'h0;
      ctrl1_r     <= 8'h0;                                    // [R16]
      ctrl3_r     <= 8'h0;
      clk_conv_r  <= 3'h0;
      perr_r      <= 1'b0;
      istat_r     <= 8'h0;
      seen_r      <= 3'h0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `FSC_A_CNT_LO:  start_cnt_r[7:0]   <= reg_wdata[7:0];
          `FSC_A_CNT_MID: start_cnt_r[15:8]  <= reg_wdata[7:0];
          `FSC_A_CNT_HI:  start_cnt_r[23:16] <= reg_wdata[7:0];
          `FSC_A_PERIOD:  period_r           <= reg_wdata[7:0];
          `FSC_A_OFFSET:  offset_r           <= reg_wdata[7:0];
          `FSC_A_CTRL1:   ctrl1_r            <= reg_wdata[7:0];
          `FSC_A_CTRL3:   ctrl3_r            <= reg_wdata[7:0];
          `FSC_A_CCF:     clk_conv_r         <= reg_wdata[2:0];
          default: ;
        endcase
      end
      if (dma_cmd)
        cur_cnt_r <= start_cnt_r;
      else if (xfer_byte && cur_cnt_r != 24'h0)
        cur_cnt_r <= cur_cnt_r - 24'h1;
      if (dma_cmd | wr_hi)
        id_valid_r <= 1'b0;                                   // [R8]
      if (perr_evt)
        perr_r <= 1'b1;                                       // [R17]
      else if (rd_stat)
        perr_r <= 1'b0;
      if (scsi_clr) begin
        istat_r <= 8'h0;
        seen_r  <= 3'h0;
      end else begin
        istat_r <= istat_r | ev;
        seen_r  <= (|istat_r) ? seen_nxt : 3'h0;
      end
    end
  end

  // ========================================================
  // Command issue, ATN, RST drive and disconnected state
  always @(posedge clk) begin
    if (hrst) begin
      need_nop_r     <= dev_rst;
      cmd_code_r     <= 8'h0;
      cmd_valid_r    <= 1'b0;
      scsi_atn_r     <= 1'b0;
      scsi_rst_out_r <= 1'b0;
      scsi_rst_oe_r  <= 1'b0;                                 // [R21]
      disconnected_r <= 1'b1;
    end else begin
      cmd_valid_r <= cmd_take & ~srst & ~drst;
      if (cmd_take)
        cmd_code_r <= wcode;
      if (cmd_take & is_nop)
        need_nop_r <= 1'b0;
      if (drst)
        cmd_code_r <= 8'h0;                                   // [R25]
      if (bus_rst) begin
        scsi_rst_out_r <= 1'b1;                               // [R21]
        scsi_rst_oe_r  <= 1'b1;
      end
      if (srst | drst) begin
        scsi_atn_r     <= 1'b0;                               // [R24]
        disconnected_r <= 1'b1;
      end else begin
        if (perr_evt | (cmd_take & (wcode == `FSC_CMD_SETATN)))
          scsi_atn_r <= 1'b1;                                 // [R17]
        else if (cmd_take & (wcode == `FSC_CMD_CLRATN))
          scsi_atn_r <= 1'b0;
        if (seq_evt[3] | (cmd_take & wcode[6]))
          disconnected_r <= 1'b0;
      end
    end
  end

  // ========================================================
  // Sync timing, REQ/ACK shaping, data drive
  reg [4:0] per_cnt_r;
  reg [2:0] hs_hist_r;
  reg [1:0] a_dly;
  reg [1:0] d_dly;
  reg       tap_a;
  reg       tap_d;
  always @* begin
    a_dly = {1'b0, offset_r[5]} + {1'b0, offset_r[4]};     // [R13]
    case ({ctrl3_r[`FSC_C3_FCLK], offset_r[7:6]})                  // [R12]
      3'b000:  d_dly = 2'd0;
      3'b001:  d_dly = 2'd1;
      3'b010:  d_dly = 2'd1;
      3'b011:  d_dly = 2'd2;
      3'b100:  d_dly = 2'd0;
      3'b101:  d_dly = 2'd0;
      3'b110:  d_dly = 2'd1;
      default: d_dly = 2'd2;
    endcase
    tap_a = (a_dly == 2'd0) ? hs_req : hs_hist_r[a_dly - 2'd1];
    tap_d = (d_dly == 2'd0) ? hs_req : hs_hist_r[d_dly - 2'd1];
  end

  wire [4:0] per_val = (period_r[4:0] == 5'h0) ? 5'h1 : period_r[4:0];
  always @(posedge clk) begin
    if (hrst | srst | drst) begin
      per_cnt_r      <= 5'h0;
      sync_tick_r    <= 1'b0;
      hs_hist_r      <= 3'h0;
      scsi_reqack_r  <= 1'b0;                                 // [R24]
      scsi_db_out_r  <= 8'h0;
      scsi_dbp_out_r <= 1'b0;
      scsi_db_oe_r   <= 1'b0;                                 // [R25]
    end else begin
      sync_tick_r <= 1'b0;
      if (offset_r[3:0] == 4'h0) begin
        per_cnt_r <= 5'h0;
      end else if (per_cnt_r <= 5'h1) begin
        per_cnt_r   <= per_val;                               // [R11]
        sync_tick_r <= 1'b1;
      end else begin
        per_cnt_r <= per_cnt_r - 5'h1;
      end
      hs_hist_r <= {hs_hist_r[1:0], hs_req};
      if (scsi_reqack_r)
        scsi_reqack_r <= tap_d;
      else
        scsi_reqack_r <= tap_a;
      scsi_db_oe_r <= tx_valid;
      if (tx_valid) begin
        scsi_db_out_r  <= tx_data;
        scsi_dbp_out_r <= ~(^tx_data);                        // [R15]
      end
    end
  end

  // ========================================================
  // DMA registers and status
  reg [7:0]  dcmd_r;
  reg [23:0] dstc_r;
  reg [31:0] dspa_r;
  reg [5:0]  dflag_r;
  wire       rd_dstat = reg_rd & (reg_addr == `FSC_A_DSTAT);
  wire       scsi_pend = |istat_r;                            // [R6]
  wire [5:0] dset;
  assign dset[`FSC_DS_ERR]  = dma_addr_err_evt &
                              dcmd_r[`FSC_DCMD_INTE_D];       // [R3]
  assign dset[`FSC_DS_POWER_DOWN_PIN] = pd_first;                       // [R4]
  assign dset[2]            = 1'b0;
  assign dset[`FSC_DS_DONE] = dma_done_evt &
                              dcmd_r[`FSC_DCMD_INTE_D];       // [R3]
  assign dset[`FSC_DS_SCSI] = 1'b0;
  assign dset[`FSC_DS_PAGE] = dma_page_evt & dcmd_r[`FSC_DCMD_MDL] &
                              dcmd_r[`FSC_DCMD_INTE_P];       // [R5]

  always @(posedge clk) begin
    if (sys_rst) begin
      dcmd_r    <= `FSC_DCMD_RST;
      dstc_r    <= 24'h0;
      dspa_r    <= 32'h0;
      dflag_r   <= 6'h0;
      pd_seen_r <= 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `FSC_A_DCMD: dcmd_r <= reg_wdata[7:0];
          `FSC_A_DSTC: dstc_r <= reg_wdata[23:0];
          `FSC_A_DSPA: dspa_r <= reg_wdata;
          default: ;
        endcase
      end
      if (pd_first)
        pd_seen_r <= 1'b1;
      if (rd_dstat)
        dflag_r <= dset;                                      // [R1]
      else
        dflag_r <= dflag_r | dset;
    end
  end

  // ========================================================
  // Read mux, interrupt and FIFO ready outputs
  reg [31:0] rmux;
  always @* begin
    case (reg_addr)
      `FSC_A_CNT_LO:  rmux = {24'h0, cur_cnt_r[7:0]};
      `FSC_A_CNT_MID: rmux = {24'h0, cur_cnt_r[15:8]};
      `FSC_A_CNT_HI:  rmux = {24'h0, id_valid_r ? BLOCK_ID :
                              cur_cnt_r[23:16]};              // [R8]
      `FSC_A_STAT:    rmux = {26'h0, perr_r, 5'h0};           // [R17]
      `FSC_A_ISTAT:   rmux = {24'h0, istat_r};
      `FSC_A_PERIOD:  rmux = {29'h0, seq_state};
      `FSC_A_CTRL1:   rmux = {24'h0, ctrl1_r};
      `FSC_A_CTRL3:   rmux = {24'h0, ctrl3_r};
      `FSC_A_DCMD:    rmux = {24'h0, dcmd_r};
      `FSC_A_DSTC:    rmux = {8'h0, dstc_r};
      `FSC_A_DSPA:    rmux = dspa_r;
      `FSC_A_DSTAT:   rmux = {26'h0, dflag_r[5],
                              scsi_pend, dflag_r[3:0]};       // [R6]
      default:        rmux = 32'h0;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata_r          <= 32'h0;
      int_n_r              <= 1'b1;
      fifo_dma_ready_r     <= 1'b0;
      count_zero_r         <= 1'b1;
      fast_timing_enable_r <= 1'b0;
      fast_clock_enable_r  <= 1'b0;
    end else begin
      if (reg_rd)
        reg_rdata_r <= rmux;
      int_n_r <= ~((|dflag_r) | scsi_pend);                  // [R26]
      fifo_dma_ready_r <= (fifo_level >= `FSC_FIFO_THR);      // [R9]
      count_zero_r <= (cur_cnt_r == 24'h0);
      fast_timing_enable_r <= ctrl3_r[`FSC_C3_FAST];          // [R10]
      fast_clock_enable_r  <= ctrl3_r[`FSC_C3_FCLK];
    end
  end

endmodule

// >>> verif/fsc_scsi_peer.sv
// ======
// Far side: a bus device sending bytes, pulsing RST
module fsc_scsi_peer (
  input  logic       clk,
  output logic [7:0] db,
  output logic       dbp,
  output logic       strobe,
  output logic       rst
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    db = 8'h00;
    dbp = 1'b0;
    strobe = 1'b0;
    rst = 1'b0;
  end
  // Odd parity unless bad, then released bus shows inverse
  task automatic send(input logic [7:0] d, input logic bad);
    @(posedge clk); #2;
    db = d;
    dbp = ~(^d) ^ bad;
    strobe = 1'b1;
    @(posedge clk); #2;
    strobe = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    db = ~d;
    dbp = ~dbp;
  endtask
  task automatic bus_reset(input int n);
    @(posedge clk); #2;
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #2;
    rst = 1'b0;
  endtask
endmodule

// >>> verif/fsc_core_assertions.sv
module fsc_core_checker #(
  parameter       FIFO_LW  = 7,
  parameter [7:0] BLOCK_ID = 8'h5a
) (
  input logic               clk,
  input logic               sys_rst,
  input logic [7:0]         reg_addr,
  input logic               reg_wr,
  input logic               reg_rd,
  input logic [31:0]        reg_wdata,
  input logic [31:0]        reg_rdata_r,
  input logic [FIFO_LW-1:0] fifo_level,
  input logic               fifo_dma_ready_r,
  input logic [7:0]         cmd_code_r,
  input logic [7:0]         scsi_db_out_r,
  input logic               scsi_dbp_out_r,
  input logic               scsi_db_oe_r,
  input logic [7:0]         scsi_db_in,
  input logic               scsi_dbp_in,
  input logic               rx_strobe,
  input logic               scsi_atn_r,
  input logic               scsi_rst_in,
  input logic               scsi_rst_oe_r,
  input logic               scsi_rst_out_r,
  input logic               disconnected_r,
  input logic               initiator,
  input logic               bus_free_evt,
  input logic               sel_timeout_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Shadow of parity enable, ID visibility, NO_OPERATION_COMMAND lockout
  logic       par_en_r;
  logic       id_ok_r;
  logic       need_nop_r;
  wire        cmd_wr = reg_wr && reg_addr == 8'h0c;
  wire  [7:0] cw     = reg_wdata[7:0];
  always @(posedge clk) begin
    if (sys_rst || (cmd_wr && cw == 8'h02)) begin
      par_en_r <= 1'b0;
      id_ok_r <= 1'b1;
      need_nop_r <= !sys_rst;
    end else begin
      if (reg_wr && reg_addr == 8'h20)
        par_en_r <= reg_wdata[4];
      if ((reg_wr && reg_addr == 8'h38) || (cmd_wr && cw[7]))
        id_ok_r <= 1'b0;
      if (cmd_wr && (cw == 8'h00 || cw == 8'h80))
        need_nop_r <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ======
  // Properties
  a_fifo_thr_ready: assert property (1 |=>
    fifo_dma_ready_r == ($past(fifo_level) >= 2))
    else $error("fifo ready does not follow level");
  a_tx_parity_odd: assert property (scsi_db_oe_r |->
    ^{scsi_db_out_r, scsi_dbp_out_r})
    else $error("driven byte has even parity");
  a_rx_err_atn: assert property (rx_strobe && par_en_r &&
    !(^{scsi_db_in, scsi_dbp_in}) |-> ##[1:4] scsi_atn_r)
    else $error("parity error without ATN");
  a_rst_drive_hold: assert property (scsi_rst_oe_r &&
    !(cmd_wr && cw == 8'h02) |=> scsi_rst_oe_r && scsi_rst_out_r)
    else $error("RST drive dropped before hard reset");
  a_bus_rst_cmd: assert property (cmd_wr && cw == 8'h03 &&
    !need_nop_r |-> ##[1:2] scsi_rst_oe_r && disconnected_r)
    else $error("bus reset command not applied");
  a_dev_rst_cmd: assert property (cmd_wr && cw == 8'h02 &&
    !need_nop_r |-> ##[1:2] !scsi_rst_oe_r && !scsi_atn_r && disconnected_r)
    else $error("device reset not applied");
  a_ext_rst_soft: assert property ($rose(scsi_rst_in) &&
    !scsi_rst_oe_r |-> ##[1:6] disconnected_r && !scsi_atn_r)
    else $error("external RST gave no soft reset");
  a_disc_reset: assert property (initiator &&
    (bus_free_evt || sel_timeout_evt) |-> ##[1:2]
    cmd_code_r == 8'h00 && disconnected_r)
    else $error("disconnected reset not applied");
  a_id_readback: assert property (reg_rd && reg_addr == 8'h38 &&
    id_ok_r |=> reg_rdata_r[7:0] == BLOCK_ID)
    else $error("identity code not returned");
endmodule

bind fsc_core fsc_core_checker #(.FIFO_LW(FIFO_LW), .BLOCK_ID(BLOCK_ID))
  u_chk (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata_r, .fifo_level, .fifo_dma_ready_r, .cmd_code_r,
  .scsi_db_out_r, .scsi_dbp_out_r, .scsi_db_oe_r, .scsi_db_in,
  .scsi_dbp_in, .rx_strobe, .scsi_atn_r, .scsi_rst_in, .scsi_rst_oe_r,
  .scsi_rst_out_r, .disconnected_r, .initiator, .bus_free_evt,
  .sel_timeout_evt);

// >>> verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary value
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, int_n_r;
  logic [7:0] reg_addr = 0, tx_data = 0, cmd_code_r, scsi_db_out_r;
  logic [31:0] reg_wdata = 0, reg_rdata_r;
  logic dma_done_evt = 0, dma_addr_err_evt = 0, dma_page_evt = 0;
  logic power_down_pin = 0, bus_free_evt = 0, sel_timeout_evt = 0;
  logic initiator = 0, hs_req = 0, tx_valid = 0, scsi_reqack_r;
  logic [3:0] seq_evt = 0;
  logic [6:0] fifo_level = 0;
  logic fifo_dma_ready_r, sync_tick_r, scsi_dbp_out_r, scsi_db_oe_r;
  logic [7:0] scsi_db_in;
  logic scsi_dbp_in, rx_strobe, scsi_atn_r, p_rst, scsi_rst_in;
  logic scsi_rst_out_r, scsi_rst_oe_r, disconnected_r;
  logic fast_t, fast_c;
  logic [2:0] cconv;
  int bad_count = 0, samples_checked = 0, i, n;
  assign scsi_rst_in = p_rst | (scsi_rst_oe_r & scsi_rst_out_r);
  always #12.5 clk = ~clk;
  fsc_core #(.FIFO_LW(7), .BLOCK_ID(ID)) u_dut (.clk, .sys_rst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .int_n_r,
    .dma_done_evt, .dma_addr_err_evt, .dma_page_evt, .power_down_pin,
    .seq_evt, .bus_free_evt, .sel_timeout_evt, .initiator,
    .seq_state(3'h0), .xfer_byte(1'b0), .fifo_level, .fifo_dma_ready_r,
    .cmd_code_r, .cmd_valid_r(), .count_zero_r(), .sync_tick_r,
    .fast_timing_enable_r(fast_t), .fast_clock_enable_r(fast_c),
    .clk_conv_r(cconv),
    .hs_req, .scsi_reqack_r, .tx_data, .tx_valid, .scsi_db_out_r,
    .scsi_dbp_out_r, .scsi_db_oe_r, .scsi_db_in, .scsi_dbp_in, .rx_strobe,
    .scsi_atn_r, .scsi_rst_in, .scsi_rst_out_r, .scsi_rst_oe_r,
    .disconnected_r);
  fsc_scsi_peer u_peer (.clk, .db(scsi_db_in), .dbp(scsi_dbp_in),
    .strobe(rx_strobe), .rst(p_rst));
  // ======
  // Access and check tasks
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1; tick(1); reg_wr = 0; tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    reg_addr = a; reg_rd = 1; tick(1); reg_rd = 0; tick(1);
    chk($sformatf("reg %h", a), reg_rdata_r & m, e);
  endtask
  task automatic dpulse(input int k);
    {dma_page_evt, dma_addr_err_evt, dma_done_evt} = 3'b001 << k;
    tick(1);
    {dma_page_evt, dma_addr_err_evt, dma_done_evt} = 3'b000;
    tick(1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
  // ======
  // Main sequence
  initial begin
    tick(10);
    sys_rst = 0;
    chk("int_n", int_n_r, 1);
    rd(8'h38, ID, 32'hff);
    rd(8'h7c, 0, '1);
    dpulse(1);
    rd(8'h54, 0, 32'hff);
    wr(8'h40, 32'h40);
    dpulse(0);
    chk("int_n", int_n_r, 0);
    rd(8'h54, 32'h08, 32'hff);
    chk("int_n", int_n_r, 1);
    dpulse(1);
    rd(8'h54, 32'h01, 32'hff);
    for (i = 0; i < 2; i++) begin
      wr(8'h40, i ? 32'h30 : 32'h20);
      dpulse(2);
      rd(8'h54, i ? 32'h20 : 0, 32'hff);
    end
    for (i = 0; i < 2; i++) begin
      power_down_pin = 1; tick(6); power_down_pin = 0; tick(6);
      rd(8'h54, i ? 0 : 32'h02, 32'hff);
    end
    $display("test dma done");
    for (i = 0; i < 5; i++) begin
      if (i == 4) wr(8'h0c, 32'h05);
      seq_evt = 4'h1 << i; tick(1); seq_evt = 0; tick(2);
      chk("int_n", int_n_r, 0);
      rd(8'h54, 32'h10, 32'h10);
      rd(8'h54, 32'h10, 32'h10);
      rd(8'h10, 0, 32'hff);
      rd(8'h18, 0, 32'hff);
      rd(8'h14, i < 4 ? 32'h20 >> i : 32'h40, 32'hfc);
      rd(8'h54, 0, 32'h10);
    end
    chk("disc", disconnected_r, 0);
    wr(8'h20, 32'h40);
    u_peer.bus_reset(4);
    tick(6);
    chk("disc", disconnected_r, 1);
    rd(8'h14, 32'h80, 32'h80);
    rd(8'h10, 0, 32'hff);
    rd(8'h18, 0, 32'hff);
    $display("test scsi int done");
    for (i = 0; i < 2; i++) begin
      wr(8'h20, i ? 32'h10 : 0);
      u_peer.send(8'h03, 1);
      tick(2);
      chk("atn", scsi_atn_r, i);
      rd(8'h10, i << 5, 32'h20);
    end
    rd(8'h54, 0, 32'h10);
    wr(8'h0c, 32'h1b);
    u_peer.send(8'ha5, 0);
    tick(2);
    chk("atn", scsi_atn_r, 0);
    tx_valid = 1;
    for (i = 0; i < 4; i++) begin
      tx_data = {i[1:0], 6'h15};
      tick(2);
      chk("tx par", ^{scsi_db_out_r, scsi_dbp_out_r}, 1);
      chk("tx data", scsi_db_out_r, tx_data);
    end
    tx_valid = 0;
    for (i = 1; i < 4; i++) begin
      fifo_level = i[6:0];
      tick(2);
      chk("fifo rdy", fifo_dma_ready_r, i >= 2);
    end
    $display("test datapath done");
    for (i = 0; i < 4; i++) begin
      wr(8'h1c, i * 8'h50);
      hs_req = 1;
      n = 0;
      while (!scsi_reqack_r && n < 8) begin tick(1); n++; end
      chk("req on", n, (i + 1) / 2 + 1);
      hs_req = 0;
      n = 0;
      while (scsi_reqack_r && n < 8) begin tick(1); n++; end
      chk("req off", n, (i + 1) / 2 + 1);
      tick(4);
    end
    wr(8'h30, 32'h18);
    wr(8'h24, 32'hf8);
    chk("fast cfg", {fast_t, fast_c, cconv}, 5'h18);
    wr(8'h1c, 32'h40);
    hs_req = 1; tick(3);
    chk("req fast on", scsi_reqack_r, 1);
    hs_req = 0; tick(1);
    chk("req fast off", scsi_reqack_r, 0);
    wr(8'h18, 32'h25);
    wr(8'h1c, 32'h01);
    n = 0;
    while (!sync_tick_r && n < 50) begin tick(1); n++; end
    tick(1);
    n = 1;
    while (!sync_tick_r && n < 50) begin tick(1); n++; end
    chk("period", n, 5);
    wr(8'h1c, 0);
    $display("test timing done");
    wr(8'h48, 32'h12345678);
    wr(8'h44, 32'h00abcdef);
    wr(8'h20, 32'h40);
    wr(8'h0c, 32'h03);
    chk("rst drv", scsi_rst_oe_r & scsi_rst_out_r, 1);
    chk("disc", disconnected_r, 1);
    rd(8'h14, 32'h80, 32'h80);
    tick(20);
    chk("rst drv", scsi_rst_oe_r, 1);
    wr(8'h0c, 32'h02);
    chk("rst drv", scsi_rst_oe_r, 0);
    rd(8'h38, ID, 32'hff);
    rd(8'h48, 32'h12345678, '1);
    rd(8'h44, 32'h00abcdef, '1);
    wr(8'h0c, 32'h03);
    chk("rst drv", scsi_rst_oe_r, 0);
    wr(8'h0c, 32'h00);
    wr(8'h0c, 32'h03);
    chk("rst drv", scsi_rst_oe_r, 1);
    wr(8'h0c, 32'h02);
    wr(8'h0c, 32'h00);
    initiator = 1;
    for (i = 0; i < 2; i++) begin
      wr(8'h0c, 32'h1a);
      chk("atn", scsi_atn_r, 1);
      {sel_timeout_evt, bus_free_evt} = 2'b01 << i; tick(1);
      {sel_timeout_evt, bus_free_evt} = 2'b00; tick(1);
      chk("cmd", cmd_code_r, 0);
      chk("atn", scsi_atn_r, 0);
    end
    $display("test resets done");
    conclude();
  end
endmodule
